/* File: psr_pkg.sv */
package psr_pkg;

	// command/address word layout
	localparam int CA_W        = 48;
	localparam int CA_DIR      = 47;
	localparam int CA_SPACE    = 46;
	localparam int CA_BURST    = 45;
	localparam int CA_DIE_HI   = 39;
	localparam int CA_DIE_LO   = 32;
	localparam int CA_GRP_HI   = 31;
	localparam int CA_GRP_LO   = 24;
	localparam int CA_IDX_HI   = 7;
	localparam int CA_IDX_LO   = 0;
	localparam int CA_ROW_HI   = 35;
	localparam int CA_DROW_HI  = 34;
	localparam int CA_ROW_LO   = 22;
	localparam int CA_COL_HI   = 21;
	localparam int CA_COL_LO   = 16;
	localparam int CA_WORD_HI  = 2;
	localparam int CA_WORD_LO  = 0;

	// last link edge index of a command/address word (six edges, counted from zero)
	localparam logic [7:0] CA_LAST_EDGE = 8'h05;

	// register groups and indices
	localparam logic [7:0] GRP_ID      = 8'h00;
	localparam logic [7:0] GRP_CFG     = 8'h01;
	localparam logic [7:0] GRP_INFO    = 8'h02;
	localparam logic [7:0] IDX_0       = 8'h00;
	localparam logic [7:0] IDX_1       = 8'h01;
	localparam logic [7:0] INFO_LAST   = 8'h11;
	localparam logic [7:0] DIE_LAST    = 8'h01;
	localparam int         INFO_WORDS  = 18;
	localparam int         INFO_AW     = 6;

	// configuration word defaults and word zero fields
	localparam logic [15:0] CR0_RESET  = 16'h8F2F;
	localparam logic [15:0] CR1_RESET  = 16'h0002;
	localparam int          CR0_LAT_HI = 7;
	localparam int          CR0_LAT_LO = 4;
	localparam int          CR0_FIXED  = 3;

	// identity word fields
	localparam logic [4:0] ID_ROW_BITS_M1 = 5'h0C;
	localparam logic [3:0] ID_COL_BITS_M1 = 4'h8;
	// maker and device codes: arbitrary values
	localparam logic [3:0] MAKER_CODE     = 4'h5;
	localparam logic [3:0] DEVICE_CODE    = 4'h3;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CA,
		ST_WDATA,
		ST_LAT,
		ST_RDATA,
		ST_DONE
	} psr_state_t;

endpackage

/* File: psr_info_rom.sv */
`timescale 1ns/1ps
module psr_info_rom
	import psr_pkg::*;
#(
	parameter int AW = INFO_AW
) (
	input  wire logic          clk_sys,
	input  wire logic [AW-1:0] addr,
	output logic      [15:0]   data_q
);

	// manufacture information contents: arbitrary values
	function automatic logic [15:0] info_word(input logic [AW-1:0] a);
		info_word = {4'h0, 6'(a), 6'(~a)};
	endfunction

	always_ff @(posedge clk_sys) begin
		data_q <= info_word(addr);
	end

endmodule

/* File: psr_reg_space.sv */
`timescale 1ns/1ps
//Contract
// - array address: row ca 35:22, upper column 21:16, word offset 2:0
// - each die has 8192 rows on ca 34:22; bit 35 picks the die
// - ca bit 46 set sends the access to register space
// - register reads accept C0h or E0h alike; burst bit ignored
// - die on ca 39:32, group on 31:24, index on 7:0
// - two read-only identity words describe the addressed die
// - identity word zero: die index in 15:14, bit 13 zero
// - identity word zero 12:8 holds row bits minus one, 01100
// - identity word zero 7:4 holds column bits minus one, 1000
// - maker code in word zero 3:0; device code in word one
// - reset loads every register with its default
// - register updates accepted at any time in standby
// - register write is one word straight after ca, no latency
// - device drives strobe in ca high on refresh or either die's fixed-latency bit; releases it after ca for writes, keeps driving for register reads
// - both write bytes load the register, never masked
// - register read returns one word after one or two latencies
// - ca bit 47 is direction, one read; bit 45 is burst type
module psr_reg_space
	import psr_pkg::*;
#(
	parameter logic [15:0] CR0_DEFAULT = CR0_RESET,
	parameter logic [15:0] CR1_DEFAULT = CR1_RESET
) (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        link_ck,
	input  wire logic        cs_n,
	input  wire logic [7:0]  dq_in,
	input  wire logic        read_write_strobe_in,
	input  wire logic        refresh_busy,
	output logic      [7:0]  dq_out,
	output logic             dq_oe,
	output logic             read_write_strobe_out,
	output logic             read_write_strobe_oe,
	output logic             array_start,
	output logic             array_die,
	output logic      [12:0] array_row,
	output logic      [5:0]  array_col,
	output logic      [2:0]  array_word
);

	typedef struct packed {
		psr_state_t        st;
		logic              ck_s1;
		logic              ck_s2;
		logic              ck_p;
		logic              cs_s1;
		logic              cs_s2;
		logic [7:0]        dq_s1;
		logic [7:0]        dq_s2;
		logic [CA_W-1:0]   ca;
		logic [7:0]        ecnt;
		logic [7:0]        last;
		logic              lat2;
		logic [7:0]        wbyte;
		logic [1:0][15:0]  cr0;
		logic [1:0][15:0]  cr1;
		logic [15:0]       rd_word;
		logic [7:0]        dq_o;
		logic              dq_en;
		logic              rw_o;
		logic              rw_en;
		logic              arr_go;
		logic              arr_die;
		logic [12:0]       arr_row;
		logic [5:0]        arr_col;
		logic [2:0]        arr_word;
	} psr_vec_t;

	psr_vec_t          r;
	psr_vec_t          n;
	logic              edge_seen;
	logic [CA_W-1:0]   ca_n;
	logic              wr_fire;
	logic [15:0]       wr_word;
	logic [15:0]       info_q;

	function automatic logic [7:0] die_of(input logic [CA_W-1:0] c);
		die_of = c[CA_DIE_HI:CA_DIE_LO];
	endfunction

	function automatic logic [7:0] grp_of(input logic [CA_W-1:0] c);
		grp_of = c[CA_GRP_HI:CA_GRP_LO];
	endfunction

	function automatic logic [7:0] idx_of(input logic [CA_W-1:0] c);
		idx_of = c[CA_IDX_HI:CA_IDX_LO];
	endfunction

	// latency clocks from the cr0 code; reserved codes fall back to 7
	function automatic logic [7:0] lat_clocks(input logic [3:0] code);
		case (code)
			4'h0: lat_clocks = 8'h05;
			4'h1: lat_clocks = 8'h06;
			4'hE: lat_clocks = 8'h03;
			4'hF: lat_clocks = 8'h04;
			default: lat_clocks = 8'h07;
		endcase
	endfunction

	function automatic logic [15:0] reg_read(
		input logic [CA_W-1:0] c,
		input logic [15:0]     c0,
		input logic [15:0]     c1,
		input logic [15:0]     info
	);
		logic [7:0] d;
		logic [7:0] i;
		reg_read = 16'h0000;
		d = die_of(c);
		i = idx_of(c);
		if (d <= DIE_LAST) begin
			case (grp_of(c))
				GRP_ID: begin
					if (i == IDX_0)
						reg_read = {d[1:0], 1'b0, ID_ROW_BITS_M1,
							ID_COL_BITS_M1, MAKER_CODE};
					else if (i == IDX_1)
						reg_read = {12'h000, DEVICE_CODE};
				end
				GRP_CFG: begin
					if (i == IDX_0)
						reg_read = c0;
					else if (i == IDX_1)
						reg_read = c1;
				end
				GRP_INFO: begin
					if (i <= INFO_LAST)
						reg_read = info;
				end
				default: reg_read = 16'h0000;
			endcase
		end
	endfunction

	psr_info_rom #(
		.AW(INFO_AW)
	) u_info (
		.clk_sys(clk_sys),
		.addr   ({r.ca[CA_DIE_LO], r.ca[4:0]}),
		.data_q (info_q)
	);

	always_comb begin
		n = r;
		edge_seen = r.ck_s2 ^ r.ck_p;
		ca_n = {r.ca[CA_W-9:0], r.dq_s2};
		wr_fire = 1'b0;
		wr_word = {r.wbyte, r.dq_s2};
		n.ck_s1 = link_ck;
		n.ck_s2 = r.ck_s1;
		n.ck_p = r.ck_s2;
		n.cs_s1 = cs_n;
		n.cs_s2 = r.cs_s1;
		n.dq_s1 = dq_in;
		n.dq_s2 = r.dq_s1;
		n.arr_go = 1'b0;
		n.rd_word = reg_read(r.ca, r.cr0[r.ca[CA_DIE_LO]],
			r.cr1[r.ca[CA_DIE_LO]], info_q);
		case (r.st)
			ST_IDLE: begin
				if (!r.cs_s2) begin
					n.st = ST_CA;
					n.ecnt = 8'h00;
					n.rw_en = 1'b1;
					n.rw_o = refresh_busy | r.cr0[0][CR0_FIXED]
						| r.cr0[1][CR0_FIXED];
				end
			end
			ST_CA: begin
				if (edge_seen) begin
					n.ca = ca_n;
					n.ecnt = r.ecnt + 8'h01;
					if (r.ecnt == CA_LAST_EDGE) begin
						n.ecnt = 8'h00;
						n.rw_en = 1'b0;
						n.rw_o = 1'b0;
						if (ca_n[CA_SPACE]) begin
							if (ca_n[CA_DIR]) begin
								n.st = ST_LAT;
								n.rw_en = 1'b1;
								n.lat2 = r.rw_o;
								n.last = (r.rw_o ?
									lat_clocks(r.cr0[ca_n[CA_DIE_LO]]
									[CR0_LAT_HI:CR0_LAT_LO]) << 2 :
									lat_clocks(r.cr0[ca_n[CA_DIE_LO]]
									[CR0_LAT_HI:CR0_LAT_LO]) << 1)
									- 8'h01;
							end else begin
								n.st = ST_WDATA;
							end
						end else begin
							n.st = ST_DONE;
							n.arr_go = 1'b1;
							// die from bit 35, 13 row bits
							n.arr_die = ca_n[CA_ROW_HI];
							n.arr_row = ca_n[CA_DROW_HI:CA_ROW_LO];
							n.arr_col = ca_n[CA_COL_HI:CA_COL_LO];
							n.arr_word = ca_n[CA_WORD_HI:CA_WORD_LO];
						end
					end
				end
			end
			ST_WDATA: begin
				if (edge_seen) begin
					if (r.ecnt == 8'h00) begin
						n.wbyte = r.dq_s2;
						n.ecnt = 8'h01;
					end else begin
						wr_fire = 1'b1;
						n.st = ST_DONE;
					end
				end
			end
			ST_LAT: begin
				if (edge_seen) begin
					n.ecnt = r.ecnt + 8'h01;
					if (r.ecnt == r.last) begin
						n.st = ST_RDATA;
						n.dq_o = r.rd_word[15:8];
						n.dq_en = 1'b1;
						n.rw_o = 1'b1;
					end
				end
			end
			ST_RDATA: begin
				if (edge_seen) begin
					n.dq_o = r.rd_word[7:0];
					n.rw_o = 1'b0;
					n.st = ST_DONE;
				end
			end
			ST_DONE: begin
				n.st = ST_DONE;
			end
			default: n.st = ST_IDLE;
		endcase
		// writes taken regardless of refresh state
		if (wr_fire && die_of(r.ca) <= DIE_LAST
			&& grp_of(r.ca) == GRP_CFG) begin
			if (idx_of(r.ca) == IDX_0)
				n.cr0[r.ca[CA_DIE_LO]] = wr_word;
			else if (idx_of(r.ca) == IDX_1)
				n.cr1[r.ca[CA_DIE_LO]] = wr_word;
		end
		// deselect ends any transaction and frees the pins
		if (r.cs_s2 && r.st != ST_IDLE) begin
			n.st = ST_IDLE;
			n.dq_en = 1'b0;
			n.rw_en = 1'b0;
			n.rw_o = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			r <= '0;
			r.cs_s1 <= 1'b1;
			r.cs_s2 <= 1'b1;
			r.cr0 <= {CR0_DEFAULT, CR0_DEFAULT};
			r.cr1 <= {CR1_DEFAULT, CR1_DEFAULT};
		end else begin
			r <= n;
		end
	end

	assign dq_out      = r.dq_o;
	assign dq_oe       = r.dq_en;
	assign read_write_strobe_out    = r.rw_o;
	assign read_write_strobe_oe     = r.rw_en;
	assign array_start = r.arr_go;
	assign array_die   = r.arr_die;
	assign array_row   = r.arr_row;
	assign array_col   = r.arr_col;
	assign array_word  = r.arr_word;

	property p_rst_load;
		@(posedge clk_sys) rst |=> r.cr0[0] == CR0_DEFAULT
			&& r.cr0[1] == CR0_DEFAULT && r.cr1[1] == CR1_DEFAULT;
	endproperty
	a_rst_load: assert property (p_rst_load)
		else $error("registers not at defaults after reset");

	property p_ca_strobe;
		@(posedge clk_sys) disable iff (rst)
		r.st == ST_CA |-> read_write_strobe_oe;
	endproperty
	a_ca_strobe: assert property (p_ca_strobe)
		else $error("strobe not driven during ca");

	property p_wr_release;
		@(posedge clk_sys) disable iff (rst)
		r.st == ST_WDATA |-> !read_write_strobe_oe && !dq_oe;
	endproperty
	a_wr_release: assert property (p_wr_release)
		else $error("strobe driven during register write data");

	property p_full_word;
		@(posedge clk_sys) disable iff (rst)
		wr_fire && r.ca[CA_DIE_HI:CA_DIE_LO] == 8'h01
			&& grp_of(r.ca) == GRP_CFG && idx_of(r.ca) == IDX_0
			&& !r.cs_s2
		|=> r.cr0[1] == $past(wr_word) && $stable(r.cr0[0]);
	endproperty
	a_full_word: assert property (p_full_word)
		else $error("register write did not load both bytes");

	property p_ro_ignore;
		@(posedge clk_sys) disable iff (rst)
		wr_fire && grp_of(r.ca) != GRP_CFG
		|=> $stable(r.cr0) && $stable(r.cr1);
	endproperty
	a_ro_ignore: assert property (p_ro_ignore)
		else $error("write to read-only word changed a register");

	property p_id0_fields;
		@(posedge clk_sys) disable iff (rst)
		r.st == ST_LAT && $stable(r.ca) && grp_of(r.ca) == GRP_ID
			&& idx_of(r.ca) == IDX_0 && die_of(r.ca) == 8'h01
		|=> r.rd_word == {2'b01, 1'b0, 5'b01100, 4'b1000, MAKER_CODE};
	endproperty
	a_id0_fields: assert property (p_id0_fields)
		else $error("identity word zero fields wrong");

	property p_id1_fields;
		@(posedge clk_sys) disable iff (rst)
		r.st == ST_LAT && grp_of(r.ca) == GRP_ID
			&& idx_of(r.ca) == IDX_1 && die_of(r.ca) == 8'h00
		|=> r.rd_word[15:4] == 12'h000;
	endproperty
	a_id1_fields: assert property (p_id1_fields)
		else $error("identity word one upper bits not zero");

	property p_lat_len;
		@(posedge clk_sys) disable iff (rst)
		$rose(r.st == ST_LAT) |-> r.last == (r.lat2 ?
			(lat_clocks(r.cr0[r.ca[CA_DIE_LO]][7:4]) << 2) - 8'h01 :
			(lat_clocks(r.cr0[r.ca[CA_DIE_LO]][7:4]) << 1) - 8'h01);
	endproperty
	a_lat_len: assert property (p_lat_len)
		else $error("read latency length wrong");

	property p_first_byte;
		@(posedge clk_sys) disable iff (rst)
		r.st == ST_LAT ##1 r.st == ST_RDATA
		|-> dq_oe && read_write_strobe_out && dq_out == $past(r.rd_word[15:8]);
	endproperty
	a_first_byte: assert property (p_first_byte)
		else $error("first read byte not high byte");

	property p_array_map;
		@(posedge clk_sys) disable iff (rst)
		array_start |-> array_row == r.ca[34:22]
			&& array_die == r.ca[35] && array_col == r.ca[21:16]
			&& array_word == r.ca[2:0];
	endproperty
	a_array_map: assert property (p_array_map)
		else $error("array address decode wrong");

endmodule

/* File: psr_host_model.sv */
`timescale 1ns/1ps
module psr_host_model
	import psr_pkg::*;
(
	input  wire logic       clk_sys,
	output logic            link_ck,
	output logic            cs_n,
	output logic      [7:0] dq_in,
	output logic            read_write_strobe_in,
	input  wire logic [7:0] dq_out,
	input  wire logic       dq_oe,
	input  wire logic       read_write_strobe_out,
	input  wire logic       read_write_strobe_oe
);
	logic [7:0]  dq_h = 8'h00;
	logic [7:0]  junk = 8'h5A;
	logic        drv  = 1'b0;
	logic [10:0] s;

	initial begin
		link_ck = 1'b0;
		cs_n    = 1'b1;
	end

	// released lines keep changing so stale data never looks valid
	always @(posedge clk_sys) junk <= ~junk;
	assign dq_in = drv ? dq_h : junk;
	assign read_write_strobe_in = read_write_strobe_oe ? read_write_strobe_out : junk[0];

	// one link edge every six clocks, 48 ns period; sample before toggling
	task automatic step(input logic [7:0] b, input logic en);
		@(posedge clk_sys) begin
			dq_h <= b;
			drv  <= en;
		end
		repeat (2) @(posedge clk_sys);
		#1;
		s = {dq_oe, read_write_strobe_oe, read_write_strobe_out, dq_out};
		@(posedge clk_sys) link_ck <= ~link_ck;
		repeat (2) @(posedge clk_sys);
	endtask

	// mode 0 write, 1 read of one word, 2 address only
	task automatic xfer(
		input  logic [47:0] ca,
		input  logic [15:0] wd,
		input  int          mode,
		output logic [15:0] rd,
		output int          nlat,
		output logic [2:0]  fl
	);
		int k;
		rd   = 16'h0000;
		nlat = 0;
		fl   = 3'b000;
		@(posedge clk_sys) cs_n <= 1'b0;
		repeat (3) @(posedge clk_sys);
		for (k = 1; k <= 6; k++) begin
			step(ca[55-8*k -: 8], 1'b1);
			if (k == 2)
				fl[2] = s[9] & s[8];
		end
		if (mode == 0) begin
			step(wd[15:8], 1'b1);
			step(wd[7:0], 1'b1);
			fl[1] = s[9];
		end else if (mode == 1) begin
			for (k = 7; k < 80 && nlat == 0; k++) begin
				step(8'h00, 1'b0);
				if (s[10] === 1'b1) begin
					nlat     = k - 7;
					rd[15:8] = s[7:0];
					fl[1]    = s[8];
				end
			end
			step(8'h00, 1'b0);
			rd[7:0] = s[7:0];
			fl[0]   = s[8];
		end
		@(posedge clk_sys) begin
			drv  <= 1'b0;
			cs_n <= 1'b1;
		end
		repeat (6) @(posedge clk_sys);
	endtask
endmodule

/* File: psr_reg_space_bench.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin \
	comparisons++; \
	if ((g) !== (e)) begin \
		miscompares++; \
		$display("unexpected %0t got %h want %h", $time, (g), (e)); \
	end \
end

module psr_reg_space_bench
	import psr_pkg::*;
;
	logic        clk_sys      = 1'b0;
	logic        rst          = 1'b1;
	logic        refresh_busy = 1'b0;
	logic        link_ck;
	logic        cs_n;
	logic        read_write_strobe_in;
	logic        dq_oe;
	logic        read_write_strobe_out;
	logic        read_write_strobe_oe;
	logic        array_start;
	logic        array_die;
	logic [7:0]  dq_in;
	logic [7:0]  dq_out;
	logic [12:0] array_row;
	logic [5:0]  array_col;
	logic [2:0]  array_word;
	logic [22:0] cap;
	logic [15:0] cr0_exp [2];
	int          seed        = 12020;
	int          miscompares = 0;
	int          comparisons = 0;
	int          starts      = 0;

	psr_reg_space uut (.clk_sys, .rst, .link_ck, .cs_n, .dq_in, .read_write_strobe_in,
		.refresh_busy, .dq_out, .dq_oe, .read_write_strobe_out, .read_write_strobe_oe, .array_start,
		.array_die, .array_row, .array_col, .array_word);
	psr_host_model host (.clk_sys, .link_ck, .cs_n, .dq_in, .read_write_strobe_in,
		.dq_out, .dq_oe, .read_write_strobe_out, .read_write_strobe_oe);

	initial begin
		forever #2 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		refresh_busy <= 1'($random(seed));
		if (array_start === 1'b1) begin
			starts++;
			cap <= {array_die, array_row, array_col, array_word};
		end
	end

	function automatic int lat_of(input logic [3:0] c);
		return c == 0 ? 5 : c == 1 ? 6 : c == 2 ? 7 :
			c == 14 ? 3 : c == 15 ? 4 : 7;
	endfunction

	function automatic logic [15:0] id0(input logic d);
		return {1'b0, d, 1'b0, ID_ROW_BITS_M1, ID_COL_BITS_M1, MAKER_CODE};
	endfunction

	function automatic logic [15:0] info(input logic d, input logic [4:0] i);
		return {4'h0, d, i, ~{d, i}};
	endfunction

	task automatic rd_chk(input logic [7:0] d, g, i, input logic [15:0] e);
		logic [15:0] v;
		int          n;
		logic [2:0]  f;
		host.xfer({(($random(seed) & 1) ? 8'hE0 : 8'hC0), d, g, 16'h0000, i},
			16'h0000, 1, v, n, f);
		`CHK(v, e)
		`CHK(n, 4 * lat_of(cr0_exp[d[0]][7:4]))
		`CHK(f, 3'b110)
	endtask

	task automatic wr(input logic [7:0] d, g, i, input logic [15:0] w);
		logic [15:0] v;
		int          n;
		logic [2:0]  f;
		host.xfer({8'h60, d, g, 16'h0000, i}, w, 0, v, n, f);
		`CHK(f, 3'b100)
	endtask

	task automatic tally_and_finish;
		if (miscompares == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		repeat (50000) @(posedge clk_sys);
		miscompares++;
		tally_and_finish;
	end

	initial begin
		logic [15:0] w;
		logic [47:0] ca;
		logic [15:0] v;
		int          n;
		logic [2:0]  f;
		logic [3:0]  codes [5];
		codes   = '{4'h0, 4'h1, 4'h2, 4'hE, 4'hF};
		cr0_exp = '{CR0_RESET, CR0_RESET};
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (4) @(posedge clk_sys);
		for (int d = 0; d < 2; d++) begin
			rd_chk(8'(d), GRP_CFG, IDX_0, CR0_RESET);
			rd_chk(8'(d), GRP_CFG, IDX_1, CR1_RESET);
			rd_chk(8'(d), GRP_ID, IDX_0, id0(1'(d)));
			rd_chk(8'(d), GRP_ID, IDX_1, {12'h000, DEVICE_CODE});
			rd_chk(8'(d), GRP_INFO, INFO_LAST, info(1'(d), 5'h11));
		end
		wr(8'h00, GRP_ID, IDX_0, 16'($random(seed)));
		wr(8'h01, GRP_INFO, 8'h03, 16'($random(seed)));
		rd_chk(8'h00, GRP_ID, IDX_0, id0(1'b0));
		rd_chk(8'h01, GRP_INFO, 8'h03, info(1'b1, 5'h03));
		for (int i = 0; i < 5; i++) begin
			w = {1'b1, 3'($random(seed)), 4'hF, codes[i], 1'b1,
				3'($random(seed))};
			for (int d = 0; d < 2; d++) begin
				wr(8'(d), GRP_CFG, IDX_0, w);
				cr0_exp[d] = w;
			end
			rd_chk(8'h00, GRP_CFG, IDX_0, w);
			rd_chk(8'h01, GRP_CFG, IDX_0, w);
		end
		w = cr0_exp[1] ^ 16'h7000;
		wr(8'h01, GRP_CFG, IDX_0, w);
		wr(8'h02, GRP_CFG, IDX_0, 16'h0000);
		cr0_exp[1] = w;
		rd_chk(8'h00, GRP_CFG, IDX_0, cr0_exp[0]);
		rd_chk(8'h01, GRP_CFG, IDX_0, w);
		for (int i = 0; i < 2; i++) begin
			ca        = 48'({$random(seed), $random(seed)});
			ca[47:46] = 2'b00;
			ca[35]    = i[0];
			host.xfer(ca, 16'h0000, 2, v, n, f);
			`CHK(cap, {ca[35], ca[34:22], ca[21:16], ca[2:0]})
		end
		`CHK(starts, 2)
		tally_and_finish;
	end
endmodule
